// >>> hw/flow_level_pkg.sv
/*
  Constants for the FIFO level and flow character status block.
  Assumes an 8-bit parallel register bus with 8-bit byte offsets.
*/
package flow_level_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 9;

  // Register byte offsets
  localparam logic [7:0] OFS_RX_FILL   = 8'h10;
  localparam logic [7:0] OFS_TX_EMPTY  = 8'h11;
  localparam logic [7:0] OFS_RESUME    = 8'h41;
  localparam logic [7:0] OFS_STOP      = 8'h42;
  localparam logic [7:0] OFS_WAKE      = 8'h43;
  localparam logic [7:0] OFS_FLOW_STAT = 8'h44;
  localparam logic [7:0] OFS_RX_LEVEL  = 8'h46;
  localparam logic [7:0] OFS_TX_LEVEL  = 8'h47;

  // Reset values
  localparam logic [7:0] RST_RESUME   = 8'h11;
  localparam logic [7:0] RST_STOP     = 8'h13;
  localparam logic [7:0] RST_WAKE     = 8'h00;
  localparam logic [7:0] RST_LEVEL    = 8'h00;
  localparam logic [7:0] READ_NONE    = 8'h00;

  // Count code 0 stands for a full 256
  localparam logic [8:0] FULL_COUNT   = 9'h100;
  localparam logic [8:0] ZERO_COUNT   = 9'h000;

  // Two-bit field codes
  localparam logic [1:0] CODE_NONE    = 2'h0;

  // Transmitter flow state, coded as its status field
  typedef enum logic [1:0] {
    TXF_NORMAL    = 2'b00,
    TXF_HALT_PEND = 2'b01,
    TXF_REENABLED = 2'b10,
    TXF_HALTED    = 2'b11
  } tx_flow_e;

  // Flow character transmit state, coded as its status field
  typedef enum logic [1:0] {
    XCS_NORMAL      = 2'b00,
    XCS_IDLE_WAIT   = 2'b01,
    XCS_STOP_PEND   = 2'b10,
    XCS_RESUME_PEND = 2'b11
  } xchar_send_e;
endpackage

// >>> hw/flow_level_regs.sv
/*
  FIFO interrupt levels, fill and empty counts, three character
  compare registers and the flow character status register.
  Assumes the FIFO counters, transmitter and mode registers sit
  outside and present their state as synchronous inputs.
*/
// Functional notes
// - Receive interrupt level register, 256 positions
// - Transmit interrupt level register, 256 positions
// - Level write overrides mode register threshold
// - Fill count code zero means 256
// - Empty count code zero means 256
// - Match outputs pulse only when separately enabled
// - Resume compare register, resets to 11h
// - Stop compare register, resets to 13h
// - Wake address compare register, resets 00h
// - Status read clears upper four bits
// - Received field: 01 stop, 10 resume
// - Received indications sticky until status read
// - Received field updates regardless of enables
// - Sent field flags each flow char sent since status read, 00 when off
// - Transmitter flow state in bits 3:2
// - Flow char send status in bits 1:0
`timescale 1ns/1ps
module flow_level_regs (
  input  wire logic       I_CLK,
  input  wire logic       I_RST_N,
  // Parallel register bus
  input  wire logic       I_CS_N,
  input  wire logic       I_RD_N,
  input  wire logic       I_WR_N,
  input  wire logic [7:0] I_ADDR,
  input  wire logic [7:0] I_DATA,
  output logic      [7:0] O_DATA,
  output logic            O_DATA_OE_N,
  // FIFO state
  input  wire logic [8:0] I_RX_FILL,
  input  wire logic [8:0] I_TX_FREE,
  input  wire logic [8:0] I_RX_MODE_LEVEL,
  input  wire logic [8:0] I_TX_MODE_LEVEL,
  output logic            O_RX_ARB_REQ,
  output logic            O_TX_ARB_REQ,
  // Receiver character stream
  input  wire logic       I_RX_CHAR_VALID,
  input  wire logic [7:0] I_RX_CHAR,
  input  wire logic       I_XCHAR_EN,
  input  wire logic       I_ADDR_EN,
  output logic            O_RESUME_MATCH,
  output logic            O_STOP_MATCH,
  output logic            O_ADDR_MATCH,
  // Automatic flow control
  input  wire logic       I_AUTO_RX_FLOW,
  input  wire logic       I_AUTO_TX_FLOW,
  input  wire logic       I_TX_BUSY,
  input  wire logic       I_TX_CHAR_DONE,
  input  wire logic       I_SEND_STOP_REQ,
  input  wire logic       I_SEND_RESUME_REQ,
  input  wire logic       I_STOP_SENT,
  input  wire logic       I_RESUME_SENT,
  input  wire logic       I_TX_FIFO_EMPTY,
  input  wire logic       I_BIT_TICK,
  output logic            O_TX_HALT,
  output logic            O_SEND_STOP,
  output logic            O_SEND_RESUME
);

  // Count to register code; 256 wraps to code zero
  function automatic logic [7:0] count_code(input logic [8:0] cnt);
    count_code = cnt[7:0];
  endfunction
  // Level code to absolute position; code zero is 256
  function automatic logic [8:0] level_pos(input logic [7:0] code);
    level_pos = (code == 8'h00) ? flow_level_pkg::FULL_COUNT
                                : {1'b0, code};
  endfunction
  // Request once a nonzero count reaches its threshold
  function automatic logic reached(input logic [8:0] cnt,
                                   input logic [8:0] thr);
    reached = (cnt != flow_level_pkg::ZERO_COUNT) && (cnt >= thr);
  endfunction

  logic [7:0] resume_char_compare_r;
  logic [7:0] stop_char_compare_r;
  logic [7:0] wake_address_compare_r;
  logic [7:0] rx_irq_level_r;
  logic [7:0] tx_irq_level_r;
  logic       rx_override_r;
  logic       tx_override_r;
  logic       rd_prev_r;
  logic       wr_prev_r;
  logic [7:0] rdata_r;
  logic       oe_n_r;
  logic       rx_arb_r;
  logic       tx_arb_r;
  logic       resume_match_r;
  logic       stop_match_r;
  logic       addr_match_r;
  logic       got_stop_r;
  logic       got_resume_r;
  logic       sent_resume_r;
  logic       sent_stop_r;
  logic       tx_halt_r;
  logic       send_stop_r;
  logic       send_resume_r;
  flow_level_pkg::tx_flow_e    tx_flow_r;
  flow_level_pkg::tx_flow_e    tx_flow_nxt;
  flow_level_pkg::xchar_send_e xsend_r;
  flow_level_pkg::xchar_send_e xsend_nxt;

  // Strobe decode; one access per strobe assertion
  wire rd_act  = ~I_CS_N & ~I_RD_N;
  wire wr_act  = ~I_CS_N & ~I_WR_N;
  wire rd_take = rd_act & ~rd_prev_r;
  wire wr_take = wr_act & ~wr_prev_r;

  // Address decode
  wire sel_rx_fill = (I_ADDR == flow_level_pkg::OFS_RX_FILL);
  wire sel_tx_emp  = (I_ADDR == flow_level_pkg::OFS_TX_EMPTY);
  wire sel_resume  = (I_ADDR == flow_level_pkg::OFS_RESUME);
  wire sel_stop    = (I_ADDR == flow_level_pkg::OFS_STOP);
  wire sel_wake    = (I_ADDR == flow_level_pkg::OFS_WAKE);
  wire sel_stat    = (I_ADDR == flow_level_pkg::OFS_FLOW_STAT);
  wire sel_rx_lvl  = (I_ADDR == flow_level_pkg::OFS_RX_LEVEL);
  wire sel_tx_lvl  = (I_ADDR == flow_level_pkg::OFS_TX_LEVEL);

  wire stat_read   = rd_take & sel_stat;

  // Character compare, raw hits
  wire hit_resume = I_RX_CHAR_VALID &
                    (I_RX_CHAR == resume_char_compare_r);
  wire hit_stop   = I_RX_CHAR_VALID &
                    (I_RX_CHAR == stop_char_compare_r);
  wire hit_addr   = I_RX_CHAR_VALID &
                    (I_RX_CHAR == wake_address_compare_r);

  // Threshold choice: level register wins once written
  wire [8:0] rx_thr = rx_override_r ? level_pos(rx_irq_level_r)
                                    : I_RX_MODE_LEVEL;
  wire [8:0] tx_thr = tx_override_r ? level_pos(tx_irq_level_r)
                                    : I_TX_MODE_LEVEL;

  // Sent field is forced to none outside automatic receiver mode
  wire [1:0] sent_field = I_AUTO_RX_FLOW ?
                          {sent_stop_r, sent_resume_r}
                          : flow_level_pkg::CODE_NONE;
  wire [7:0] stat_value = {got_resume_r, got_stop_r, sent_field,
                           tx_flow_r, xsend_r};

  // Read data mux; unmapped offsets read as zero
  wire [7:0] rd_mux =
    sel_rx_fill ? count_code(I_RX_FILL) :
    sel_tx_emp  ? count_code(I_TX_FREE) :
    sel_resume  ? resume_char_compare_r :
    sel_stop    ? stop_char_compare_r :
    sel_wake    ? wake_address_compare_r :
    sel_stat    ? stat_value :
    sel_rx_lvl  ? rx_irq_level_r :
    sel_tx_lvl  ? tx_irq_level_r :
    flow_level_pkg::READ_NONE;

  // Bus strobe history and read data capture
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rd_prev_r <= 1'b0;
      wr_prev_r <= 1'b0;
      rdata_r   <= flow_level_pkg::READ_NONE;
      oe_n_r    <= 1'b1;
    end else begin
      rd_prev_r <= rd_act;
      wr_prev_r <= wr_act;
      oe_n_r    <= ~rd_act; // Drive from one clock after the read strobe begins until one clock after it ends
      if (rd_take) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // Writable registers; a level write holds off the mode bits until reset
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      resume_char_compare_r  <= flow_level_pkg::RST_RESUME;
      stop_char_compare_r    <= flow_level_pkg::RST_STOP;
      wake_address_compare_r <= flow_level_pkg::RST_WAKE;
      rx_irq_level_r         <= flow_level_pkg::RST_LEVEL;
      tx_irq_level_r         <= flow_level_pkg::RST_LEVEL;
      rx_override_r          <= 1'b0;
      tx_override_r          <= 1'b0;
    end else if (wr_take) begin
      if (sel_resume) begin
        resume_char_compare_r <= I_DATA;
      end
      if (sel_stop) begin
        stop_char_compare_r <= I_DATA;
      end
      if (sel_wake) begin
        wake_address_compare_r <= I_DATA;
      end
      if (sel_rx_lvl) begin
        rx_irq_level_r <= I_DATA;
        rx_override_r  <= 1'b1;
      end
      if (sel_tx_lvl) begin
        tx_irq_level_r <= I_DATA;
        tx_override_r  <= 1'b1;
      end
    end
  end

  // Arbitration requests, registered
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rx_arb_r <= 1'b0;
      tx_arb_r <= 1'b0;
    end else begin
      rx_arb_r <= reached(I_RX_FILL, rx_thr);
      tx_arb_r <= reached(I_TX_FREE, tx_thr);
    end
  end

  // Match pulses leave the block only when their function is on
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      resume_match_r <= 1'b0;
      stop_match_r   <= 1'b0;
      addr_match_r   <= 1'b0;
    end else begin
      resume_match_r <= hit_resume & I_XCHAR_EN;
      stop_match_r   <= hit_stop & I_XCHAR_EN;
      addr_match_r   <= hit_addr & I_ADDR_EN;
    end
  end

  // Received indications; a hit in the read cycle survives the clear
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      got_stop_r   <= 1'b0;
      got_resume_r <= 1'b0;
    end else begin
      got_stop_r   <= hit_stop |
                      (got_stop_r & ~stat_read);
      got_resume_r <= hit_resume |
                      (got_resume_r & ~stat_read);
    end
  end

  // Sent indications, cleared by read or by leaving automatic mode
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sent_stop_r   <= 1'b0;
      sent_resume_r <= 1'b0;
    end else if (!I_AUTO_RX_FLOW) begin
      sent_stop_r   <= 1'b0;
      sent_resume_r <= 1'b0;
    end else begin
      sent_stop_r   <= I_STOP_SENT |
                       (sent_stop_r & ~stat_read);
      sent_resume_r <= I_RESUME_SENT |
                       (sent_resume_r & ~stat_read);
    end
  end

  // Transmitter flow state; a stop during a character waits for its end
  always_comb begin
    tx_flow_nxt = tx_flow_r;
    case (tx_flow_r)
      flow_level_pkg::TXF_NORMAL: begin
        if (hit_stop) begin
          tx_flow_nxt = I_TX_BUSY ? flow_level_pkg::TXF_HALT_PEND
                                  : flow_level_pkg::TXF_HALTED;
        end
      end
      flow_level_pkg::TXF_HALT_PEND: begin
        if (hit_resume) begin
          tx_flow_nxt = flow_level_pkg::TXF_NORMAL;
        end else if (I_TX_CHAR_DONE) begin
          tx_flow_nxt = flow_level_pkg::TXF_HALTED;
        end
      end
      flow_level_pkg::TXF_HALTED: begin
        if (hit_resume) begin
          tx_flow_nxt = flow_level_pkg::TXF_REENABLED;
        end
      end
      flow_level_pkg::TXF_REENABLED: begin
        if (hit_stop) begin
          tx_flow_nxt = I_TX_BUSY ? flow_level_pkg::TXF_HALT_PEND
                                  : flow_level_pkg::TXF_HALTED;
        end else if (stat_read) begin
          tx_flow_nxt = flow_level_pkg::TXF_NORMAL;
        end
      end
      default: begin
        tx_flow_nxt = flow_level_pkg::TXF_NORMAL;
      end
    endcase
    if (!I_AUTO_TX_FLOW) begin
      tx_flow_nxt = flow_level_pkg::TXF_NORMAL;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tx_flow_r <= flow_level_pkg::TXF_NORMAL;
      tx_halt_r <= 1'b0;
    end else begin
      tx_flow_r <= tx_flow_nxt;
      tx_halt_r <= (tx_flow_nxt == flow_level_pkg::TXF_HALTED);
    end
  end

  // Flow character send state; stop request outranks resume
  always_comb begin
    xsend_nxt = xsend_r;
    case (xsend_r)
      flow_level_pkg::XCS_NORMAL,
      flow_level_pkg::XCS_IDLE_WAIT: begin
        if (I_SEND_STOP_REQ) begin
          xsend_nxt = flow_level_pkg::XCS_STOP_PEND;
        end else if (I_SEND_RESUME_REQ) begin
          xsend_nxt = flow_level_pkg::XCS_RESUME_PEND;
        end else if (xsend_r == flow_level_pkg::XCS_IDLE_WAIT &&
                     I_BIT_TICK && !I_TX_FIFO_EMPTY) begin
          xsend_nxt = flow_level_pkg::XCS_NORMAL;
        end
      end
      flow_level_pkg::XCS_STOP_PEND: begin
        if (I_STOP_SENT) begin
          xsend_nxt = flow_level_pkg::XCS_IDLE_WAIT;
        end
      end
      flow_level_pkg::XCS_RESUME_PEND: begin
        if (I_RESUME_SENT) begin
          xsend_nxt = flow_level_pkg::XCS_IDLE_WAIT;
        end
      end
      default: begin
        xsend_nxt = flow_level_pkg::XCS_NORMAL;
      end
    endcase
  end

  // Pending holds until the matching sent pulse; nothing here bounds its length
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      xsend_r       <= flow_level_pkg::XCS_NORMAL;
      send_stop_r   <= 1'b0;
      send_resume_r <= 1'b0;
    end else begin
      xsend_r       <= xsend_nxt;
      send_stop_r   <= (xsend_nxt == flow_level_pkg::XCS_STOP_PEND);
      send_resume_r <= (xsend_nxt == flow_level_pkg::XCS_RESUME_PEND);
    end
  end

  assign O_DATA         = rdata_r;
  assign O_DATA_OE_N    = oe_n_r;
  assign O_RX_ARB_REQ   = rx_arb_r;
  assign O_TX_ARB_REQ   = tx_arb_r;
  assign O_RESUME_MATCH = resume_match_r;
  assign O_STOP_MATCH   = stop_match_r;
  assign O_ADDR_MATCH   = addr_match_r;
  assign O_TX_HALT      = tx_halt_r;
  assign O_SEND_STOP    = send_stop_r;
  assign O_SEND_RESUME  = send_resume_r;

endmodule

// >>> verification/flow_level_props.sv
/*
  Checker for the level, count and flow status register block.
  Sees only top-level ports; bound to every flow_level_regs.
*/
`timescale 1ns/1ps
module flow_level_props (
  input wire logic       I_CLK,
  input wire logic       I_RST_N,
  input wire logic       I_CS_N,
  input wire logic       I_RD_N,
  input wire logic       I_WR_N,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_DATA,
  input wire logic [7:0] O_DATA,
  input wire logic       O_DATA_OE_N,
  input wire logic [8:0] I_RX_FILL,
  input wire logic       O_RX_ARB_REQ,
  input wire logic       I_RX_CHAR_VALID,
  input wire logic [7:0] I_RX_CHAR,
  input wire logic       I_XCHAR_EN,
  input wire logic       I_ADDR_EN,
  input wire logic       O_RESUME_MATCH,
  input wire logic       O_STOP_MATCH,
  input wire logic       O_ADDR_MATCH,
  input wire logic       I_SEND_STOP_REQ,
  input wire logic       I_SEND_RESUME_REQ,
  input wire logic       I_STOP_SENT,
  input wire logic       I_RESUME_SENT,
  input wire logic       O_SEND_STOP,
  input wire logic       O_SEND_RESUME
);
  logic       rd_prev_r;
  logic       wr_prev_r;
  logic [7:0] resume_r;
  logic [7:0] stop_r;
  logic [7:0] wake_r;
  // Strobe edge detection, as the block takes accesses
  wire        rd_act  = !I_CS_N && !I_RD_N;
  wire        wr_act  = !I_CS_N && !I_WR_N;
  wire        rd_take = rd_act && !rd_prev_r;
  wire        wr_take = wr_act && !wr_prev_r;
  wire        ev      = I_RX_CHAR_VALID || I_STOP_SENT || I_RESUME_SENT;
  wire  [7:0] rx_low  = I_RX_FILL[7:0];

  // Shadow copies of the compare values, so match checks follow writes
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rd_prev_r <= 1'b0;
      wr_prev_r <= 1'b0;
      resume_r  <= flow_level_pkg::RST_RESUME;
      stop_r    <= flow_level_pkg::RST_STOP;
      wake_r    <= flow_level_pkg::RST_WAKE;
    end else begin
      rd_prev_r <= rd_act;
      wr_prev_r <= wr_act;
      if (wr_take && I_ADDR == flow_level_pkg::OFS_RESUME) resume_r <= I_DATA;
      if (wr_take && I_ADDR == flow_level_pkg::OFS_STOP) stop_r <= I_DATA;
      if (wr_take && I_ADDR == flow_level_pkg::OFS_WAKE) wake_r <= I_DATA;
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  // Status read with no event landing at its take edge
  sequence s_stat_rd;
    rd_take && I_ADDR == flow_level_pkg::OFS_FLOW_STAT && !ev;
  endsequence
  sequence s_stop_out;
    O_SEND_STOP && I_STOP_SENT && !I_SEND_STOP_REQ && !I_SEND_RESUME_REQ;
  endsequence

  AST_RD_OE: assert property (rd_take |=> !O_DATA_OE_N)
    else $error("read take not answered with bus drive");
  AST_OE_RELEASE: assert property (!rd_act |=> O_DATA_OE_N)
    else $error("bus still driven after read strobe ended");
  AST_RX_COUNT: assert property (
    rd_take && I_ADDR == flow_level_pkg::OFS_RX_FILL |=> O_DATA == $past(rx_low))
    else $error("fill count read wrong");
  AST_STAT_CLEAR: assert property (
    s_stat_rd ##1 !ev ##1 s_stat_rd |=> O_DATA[7:4] == 4'h0)
    else $error("status upper bits not cleared by read");
  AST_STOP_MATCH: assert property (
    I_RX_CHAR_VALID && I_XCHAR_EN && I_RX_CHAR == stop_r |=> O_STOP_MATCH)
    else $error("stop character match missed");
  AST_RESUME_MATCH: assert property (
    I_RX_CHAR_VALID && I_XCHAR_EN && I_RX_CHAR == resume_r |=> O_RESUME_MATCH)
    else $error("resume character match missed");
  AST_ADDR_MATCH: assert property (
    I_RX_CHAR_VALID && I_ADDR_EN && I_RX_CHAR == wake_r |=> O_ADDR_MATCH)
    else $error("wake address match missed");
  AST_MATCH_GATED: assert property (
    !(I_RX_CHAR_VALID && I_XCHAR_EN) |=> !O_STOP_MATCH && !O_RESUME_MATCH)
    else $error("flow match pulse while disabled");
  AST_RX_ARB_FULL: assert property (I_RX_FILL == 9'h100 |=> O_RX_ARB_REQ)
    else $error("full receive fifo not arbitrating");
  AST_RX_ARB_EMPTY: assert property (I_RX_FILL == 9'h000 |=> !O_RX_ARB_REQ)
    else $error("empty receive fifo arbitrating");
  AST_SEND_STOP: assert property (
    I_SEND_STOP_REQ && !I_STOP_SENT && !O_SEND_RESUME |=> O_SEND_STOP && !O_SEND_RESUME)
    else $error("stop send not pending after request");
  AST_STOP_DONE: assert property (s_stop_out |=> !O_SEND_STOP && !O_SEND_RESUME)
    else $error("stop send still pending after sent");
endmodule

bind flow_level_regs flow_level_props u_props (
  .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_CS_N(I_CS_N), .I_RD_N(I_RD_N),
  .I_WR_N(I_WR_N), .I_ADDR(I_ADDR), .I_DATA(I_DATA), .O_DATA(O_DATA),
  .O_DATA_OE_N(O_DATA_OE_N), .I_RX_FILL(I_RX_FILL), .O_RX_ARB_REQ(O_RX_ARB_REQ),
  .I_RX_CHAR_VALID(I_RX_CHAR_VALID), .I_RX_CHAR(I_RX_CHAR), .I_XCHAR_EN(I_XCHAR_EN),
  .I_ADDR_EN(I_ADDR_EN), .O_RESUME_MATCH(O_RESUME_MATCH), .O_STOP_MATCH(O_STOP_MATCH),
  .O_ADDR_MATCH(O_ADDR_MATCH), .I_SEND_STOP_REQ(I_SEND_STOP_REQ),
  .I_SEND_RESUME_REQ(I_SEND_RESUME_REQ), .I_STOP_SENT(I_STOP_SENT),
  .I_RESUME_SENT(I_RESUME_SENT), .O_SEND_STOP(O_SEND_STOP), .O_SEND_RESUME(O_SEND_RESUME)
);

// >>> verification/host_bus_model.sv
/*
  Host processor model for the block's parallel register bus.
  Strobes change off the falling clock edge; the bench calls its tasks.
*/
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_data,
  input  wire logic       i_data_oe_n,
  output logic            o_cs_n,
  output logic            o_rd_n,
  output logic            o_wr_n,
  output logic [7:0]      o_addr,
  output logic [7:0]      o_data
);
  initial begin
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_addr = 8'hFF;
    o_data = 8'hFF;
  end

  // Read data only counts while the block drives the bus
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_cs_n = 1'b0;
    o_rd_n = 1'b0;
    @(negedge i_clk);
    d = (i_data_oe_n === 1'b0) ? i_data : 8'hXX;
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_addr = ~a;
  endtask

  // Released lines show the inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge i_clk);
    o_addr = a;
    o_data = v;
    o_cs_n = 1'b0;
    o_wr_n = 1'b0;
    @(negedge i_clk);
    o_cs_n = 1'b1;
    o_wr_n = 1'b1;
    o_addr = ~a;
    o_data = ~v;
  endtask
endmodule

// >>> verification/tb.sv
/*
  Self-checking bench for the level, count and flow status block.
  Host model on the register bus; every other input driven here.
*/
`timescale 1ns/1ps
module tb;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       cs_n, rd_n, wr_n, oe_n, rx_arb, tx_arb, tx_halt, send_stop, send_resume;
  logic [7:0] addr, wdata, rdata, d, ch = 8'h00;
  logic       ch_valid = 1'b0, xchar_en = 1'b0, addr_en = 1'b0, m_res, m_stop, m_addr;
  logic       auto_rx = 1'b0, auto_tx = 1'b0, tx_busy = 1'b0, fifo_empty = 1'b1;
  logic [8:0] rx_fill = 9'h000, tx_free = 9'h000, mode_lvl = 9'h005;
  logic [5:0] pul = 6'h00;
  logic [2:0] hit;
  int         fail_count = 0;
  int         n_tests = 0;
  logic [7:0] ofs [3] = '{8'h41, 8'h42, 8'h43};
  logic [7:0] rst_v [3] = '{8'h11, 8'h13, 8'h00};
  logic [7:0] new_v [3] = '{8'h31, 8'h33, 8'h5A};

  always #2.5 clk = ~clk;

  flow_level_regs u_dut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_CS_N(cs_n), .I_RD_N(rd_n), .I_WR_N(wr_n),
    .I_ADDR(addr), .I_DATA(wdata), .O_DATA(rdata), .O_DATA_OE_N(oe_n),
    .I_RX_FILL(rx_fill), .I_TX_FREE(tx_free), .I_RX_MODE_LEVEL(mode_lvl),
    .I_TX_MODE_LEVEL(mode_lvl), .O_RX_ARB_REQ(rx_arb), .O_TX_ARB_REQ(tx_arb),
    .I_RX_CHAR_VALID(ch_valid), .I_RX_CHAR(ch), .I_XCHAR_EN(xchar_en), .I_ADDR_EN(addr_en),
    .O_RESUME_MATCH(m_res), .O_STOP_MATCH(m_stop), .O_ADDR_MATCH(m_addr),
    .I_AUTO_RX_FLOW(auto_rx), .I_AUTO_TX_FLOW(auto_tx), .I_TX_BUSY(tx_busy),
    .I_TX_CHAR_DONE(pul[0]), .I_SEND_STOP_REQ(pul[1]), .I_SEND_RESUME_REQ(pul[2]),
    .I_STOP_SENT(pul[3]), .I_RESUME_SENT(pul[4]), .I_TX_FIFO_EMPTY(fifo_empty),
    .I_BIT_TICK(pul[5]), .O_TX_HALT(tx_halt), .O_SEND_STOP(send_stop),
    .O_SEND_RESUME(send_resume)
  );
  host_bus_model u_host (
    .i_clk(clk), .i_data(rdata), .i_data_oe_n(oe_n), .o_cs_n(cs_n), .o_rd_n(rd_n),
    .o_wr_n(wr_n), .o_addr(addr), .o_data(wdata)
  );

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string name);
    u_host.rd(a, d);
    chk(name, exp, d);
  endtask
  task automatic st(input logic [7:0] exp);
    rdc(flow_level_pkg::OFS_FLOW_STAT, exp, "flow status");
  endtask
  // Match pulses stand one cycle, so sample them as valid drops
  task automatic rx_char(input logic [7:0] c);
    @(negedge clk);
    ch_valid = 1'b1;
    ch = c;
    @(negedge clk);
    ch_valid = 1'b0;
    ch = ~c;
    hit = {m_res, m_stop, m_addr};
  endtask
  task automatic pulse(input logic [5:0] p);
    @(negedge clk);
    pul = p;
    @(negedge clk);
    pul = 6'h00;
  endtask
  // Same count on both FIFOs: arbitration and count readback together
  task automatic lvl(input logic [8:0] n, input logic e);
    @(negedge clk);
    rx_fill = n;
    tx_free = n;
    @(negedge clk);
    chk("rx arbitration", {7'h00, e}, {7'h00, rx_arb});
    chk("tx arbitration", {7'h00, e}, {7'h00, tx_arb});
    rdc(flow_level_pkg::OFS_RX_FILL, n[7:0], "rx fill count");
    rdc(flow_level_pkg::OFS_TX_EMPTY, n[7:0], "tx empty count");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 3; i++) begin
      rdc(ofs[i], rst_v[i], "compare reset");
      u_host.wr(ofs[i], new_v[i]);
      rdc(ofs[i], new_v[i], "compare readback");
    end
    st(8'h00);
    rdc(8'h20, 8'h00, "unmapped read");
    // Mode threshold of 5 rules until a level register is written
    lvl(9'h000, 1'b0);
    lvl(9'h004, 1'b0);
    lvl(9'h005, 1'b1);
    u_host.wr(flow_level_pkg::OFS_RX_LEVEL, 8'h0A);
    u_host.wr(flow_level_pkg::OFS_TX_LEVEL, 8'h0A);
    rdc(flow_level_pkg::OFS_RX_LEVEL, 8'h0A, "rx level");
    rdc(flow_level_pkg::OFS_TX_LEVEL, 8'h0A, "tx level");
    lvl(9'h005, 1'b0);
    lvl(9'h00A, 1'b1);
    u_host.wr(flow_level_pkg::OFS_RX_LEVEL, 8'h00);
    u_host.wr(flow_level_pkg::OFS_TX_LEVEL, 8'h00);
    lvl(9'h0FF, 1'b0);
    lvl(9'h100, 1'b1);
    u_host.wr(flow_level_pkg::OFS_RX_FILL, 8'h55);
    lvl(9'h001, 1'b0);
    // Received flow characters, match pulses disabled then enabled
    rx_char(8'h33);
    chk("gated match", 8'h00, {5'h00, hit});
    rx_char(8'h31);
    st(8'hC0);
    st(8'h00);
    rx_char(8'h33);
    st(8'h40);
    xchar_en = 1'b1;
    addr_en = 1'b1;
    rx_char(8'h31);
    chk("resume match", 8'h04, {5'h00, hit});
    rx_char(8'h5A);
    chk("address match", 8'h01, {5'h00, hit});
    addr_en = 1'b0;
    rx_char(8'h5A);
    chk("address gated", 8'h00, {5'h00, hit});
    st(8'h80);
    // Automatic transmit flow: direct halt, then halt pending
    auto_tx = 1'b1;
    rx_char(8'h33);
    chk("stop match", 8'h02, {5'h00, hit});
    chk("tx halted", 8'h01, {7'h00, tx_halt});
    st(8'h4C);
    rx_char(8'h31);
    st(8'h88);
    st(8'h00);
    tx_busy = 1'b1;
    rx_char(8'h33);
    st(8'h44);
    pulse(6'h01);
    st(8'h0C);
    rx_char(8'h31);
    st(8'h88);
    auto_tx = 1'b0;
    tx_busy = 1'b0;
    // Sent field only lives in automatic receiver flow mode
    auto_rx = 1'b1;
    pulse(6'h08);
    pulse(6'h10);
    st(8'h30);
    st(8'h00);
    pulse(6'h08);
    auto_rx = 1'b0;
    st(8'h00);
    // Send status: pending, idle wait, back to normal
    pulse(6'h02);
    chk("send stop", 8'h01, {7'h00, send_stop});
    st(8'h02);
    pulse(6'h08);
    st(8'h01);
    fifo_empty = 1'b0;
    pulse(6'h20);
    st(8'h00);
    fifo_empty = 1'b1;
    pulse(6'h04);
    chk("send resume", 8'h01, {7'h00, send_resume});
    pulse(6'h10);
    pulse(6'h20);
    st(8'h01);
    // Mid-run reset: thresholds fall back to the mode level
    @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    st(8'h00);
    rdc(flow_level_pkg::OFS_STOP, 8'h13, "stop after reset");
    lvl(9'h005, 1'b1);
    give_verdict();
  end

  // Sequence needs well under a thousand cycles; this allows plenty
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
endmodule
